// File: core/srq_defines.svh
`ifndef SRQ_DEFINES_SVH
`define SRQ_DEFINES_SVH
`define SRQ_W 8
`define SRQ_SLOTS 10
`define SRQ_SLOT_MAX 4'h9
`define SRQ_CFG_W 32
`define SRQ_STB_LOCAL 0
`define SRQ_STB_ERRQ 2
`define SRQ_STB_QUESTIONABLE_SUMMARY 3
`define SRQ_STB_MAV 4
`define SRQ_STB_ESB 5
`define SRQ_STB_RQS 6
`define SRQ_ESR_OPC 0
`define SRQ_ESR_QYE 2
`define SRQ_ESR_EXE 4
`define SRQ_ESR_CME 5
`define SRQ_ESR_PON 7
`define SRQ_ESR_USED 8'hb5
`define SRQ_STB_SRQ_MASK 8'hbf
`define SRQ_ZERO8 8'h00
`define SRQ_ESE_RST 8'h00
`define SRQ_SRE_RST 8'h00
`define SRQ_ESR_RST 8'h80
`define SRQ_ERRQ_MAX 4'hf
`endif

// File: core/srq_pkg.sv
package srq_pkg;
	typedef enum logic {
		srq_syn_scpi,
		srq_syn_native
	} srq_syntax_t;
	typedef enum logic [1:0] {
		srq_trig_immediate,
		srq_trig_bus,
		srq_trig_external
	} srq_trig_src_t;
endpackage : srq_pkg

// File: core/srq_status.sv
`timescale 1ns/10ps
`default_nettype none
`include "srq_defines.svh"
// Function
// - Recall command loads configuration from slot 0 to 9.
// - Save command stores present configuration into slot 0 to 9.
// - Bus trigger acts only when trigger source is bus.
// - Two commands switch syntax between SCPI and native.
// - Summary bits set when enabled lower-level condition present.
// - Enable mask AND status byte, ORed, gives bit 6 and request.
// - Host writes and reads request mask, reads status byte.
// - Status bit 0 set when local key pressed under remote.
// - Status bits 1 and 7 always read zero.
// - Status bit 2 set when language error is recorded.
// - Status bit 3 set on questionable condition.
// - Status bit 4 set while a response waits in output queue.
// - Event flags AND enable mask, ORed, set status bit 5.
// - Host writes and reads event mask, reads event flags.
// - Event bit 0 set when pending operations complete.
// - Event bits 1, 3 and 6 always read zero.
// - Event bit 2 set on query error.
// - Event bit 4 set on execution error.
// - Event bit 5 set on invalid bus command.
// - Event bit 7 set after power cycle.
// - Clear-status clears event flags and empties error queue, except for an event set or an error pushed in the same cycle.
module srq_status (
	input wire logic clock,
	input wire logic resetn,
	input wire logic ese_write,
	input wire logic [7:0] ese_wdata,
	input wire logic sre_write,
	input wire logic [7:0] sre_wdata,
	input wire logic esr_read,
	input wire logic clear_status,
	input wire logic opc_done,
	input wire logic query_error,
	input wire logic exec_error,
	input wire logic command_error,
	input wire logic error_push,
	input wire logic error_pop,
	input wire logic local_key,
	input wire logic remote_mode,
	input wire logic questionable_summary,
	input wire logic msg_available,
	input wire logic save_cmd,
	input wire logic recall_cmd,
	input wire logic [3:0] slot,
	input wire logic [31:0] cfg_in,
	input wire logic trig_cmd,
	input wire logic [1:0] trig_source,
	input wire logic syntax_scpi_cmd,
	input wire logic syntax_native_cmd,
	output logic [7:0] summary_status_byte,
	output logic [7:0] standard_event_flags,
	output logic [7:0] ese_readback,
	output logic [7:0] sre_readback,
	output logic service_request,
	output logic [31:0] cfg_out,
	output logic cfg_load,
	output logic trig_fire,
	output logic syntax_native,
	output logic [3:0] error_count
);
	logic [7:0] ese_reg;
	logic [7:0] sre_reg;
	logic [7:0] esr_reg;
	logic [7:0] esr_next;
	logic local_reg;
	logic [3:0] errq_reg;
	logic [`SRQ_CFG_W-1:0] slot_mem [`SRQ_SLOTS];
	srq_pkg::srq_syntax_t syntax_reg;
	wire slot_ok = slot <= `SRQ_SLOT_MAX;
	wire do_save = save_cmd && slot_ok;
	wire do_recall = recall_cmd && slot_ok;
	wire bus_src = trig_source == 2'(srq_pkg::srq_trig_bus);
	wire [7:0] esr_set;
	wire esb;
	wire [7:0] stb_low;
	wire rqs;
	wire [7:0] stb_full;
	wire errq_push = error_push && errq_reg != `SRQ_ERRQ_MAX;
	wire errq_pop = error_pop && errq_reg != 4'h0;
	// Event sources, unused positions stay zero
	assign esr_set = {1'b0, 1'b0, command_error, exec_error, 1'b0,
		query_error, 1'b0, opc_done};
	// Set wins over a coincident clear so no event is lost
	assign esr_next = ((clear_status ? `SRQ_ZERO8 : esr_reg) | esr_set)
		& `SRQ_ESR_USED;
	assign esb = |(esr_reg & ese_reg);
	assign stb_low = {1'b0, 1'b0, esb, msg_available,
		questionable_summary, errq_reg != 4'h0, 1'b0,
		local_reg};
	assign rqs = |(stb_low & sre_reg & `SRQ_STB_SRQ_MASK);
	assign stb_full = stb_low | {1'b0, rqs, 6'h00};
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			// Power-up leaves the power-on flag raised
			esr_reg <= `SRQ_ESR_RST;
			ese_reg <= `SRQ_ESE_RST;
			sre_reg <= `SRQ_SRE_RST;
		end else begin
			// Reading the event flags clears them, unless an event is set in the same cycle
			esr_reg <= (esr_read && !(|esr_set)) ? `SRQ_ZERO8 : esr_next;
			if (ese_write) begin
				ese_reg <= ese_wdata;
			end
			if (sre_write) begin
				sre_reg <= sre_wdata;
			end
		end
	end
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			local_reg <= 1'b0;
			errq_reg <= 4'h0;
		end else begin
			if (local_key && remote_mode) begin
				local_reg <= 1'b1;
			end else if (clear_status) begin
				local_reg <= 1'b0;
			end
			if (clear_status && !error_push) begin
				errq_reg <= 4'h0;
			end else if (clear_status) begin
				errq_reg <= 4'h1;
			end else if (errq_push && !errq_pop) begin
				errq_reg <= errq_reg + 4'h1;
			end else if (errq_pop && !errq_push) begin
				errq_reg <= errq_reg - 4'h1;
			end
		end
	end
	always_ff @(posedge clock) begin
		if (do_save) begin
			slot_mem[slot] <= cfg_in;
		end
	end
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cfg_out <= 32'h00000000;
			cfg_load <= 1'b0;
			trig_fire <= 1'b0;
			syntax_reg <= srq_pkg::srq_syn_scpi;
		end else begin
			cfg_load <= do_recall;
			if (do_recall) begin
				cfg_out <= slot_mem[slot];
			end
			trig_fire <= trig_cmd && bus_src;
			if (syntax_scpi_cmd) begin
				syntax_reg <= srq_pkg::srq_syn_scpi;
			end else if (syntax_native_cmd) begin
				syntax_reg <= srq_pkg::srq_syn_native;
			end
		end
	end
	// Outputs registered, so they trail the state by one cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			summary_status_byte <= `SRQ_ZERO8;
			standard_event_flags <= `SRQ_ZERO8;
			ese_readback <= `SRQ_ZERO8;
			sre_readback <= `SRQ_ZERO8;
			service_request <= 1'b0;
			syntax_native <= 1'b0;
			error_count <= 4'h0;
		end else begin
			summary_status_byte <= stb_full;
			standard_event_flags <= esr_reg;
			ese_readback <= ese_reg;
			sre_readback <= sre_reg;
			service_request <= rqs;
			syntax_native <= syntax_reg == srq_pkg::srq_syn_native;
			error_count <= errq_reg;
		end
	end
endmodule : srq_status
`default_nettype wire

// File: sim/srq_status_sva.sv
`timescale 1ns/10ps
`default_nettype none
module srq_status_sva (
	input wire logic clock, resetn, command_error, clear_status, sre_write,
	input wire logic trig_cmd, recall_cmd, trig_fire, cfg_load,
	input wire logic questionable_summary, service_request,
	input wire logic [1:0] trig_source,
	input wire logic [3:0] slot,
	input wire logic [7:0] sre_wdata, sre_readback,
	input wire logic [7:0] summary_status_byte, standard_event_flags
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence bus_trig; trig_cmd && trig_source == 2'h1; endsequence
	sequence mask_wr; sre_write ##1 !sre_write; endsequence
	stb_spare_a: assert property (summary_status_byte[7] == 1'b0 &&
		summary_status_byte[1] == 1'b0) else $error("status spare set");
	esr_spare_a: assert property ((standard_event_flags & 8'h4a) == 8'h00)
		else $error("event spare set");
	rqs_link_a: assert property (service_request ==
		|(summary_status_byte & sre_readback & 8'hbf))
		else $error("request mismatch");
	rqs_bit_a: assert property (service_request == summary_status_byte[6])
		else $error("request bit mismatch");
	cmd_err_a: assert property (command_error && !clear_status |-> ##2
		standard_event_flags[5]) else $error("command error lost");
	trig_go_a: assert property (bus_trig |=> trig_fire)
		else $error("bus trigger lost");
	trig_ign_a: assert property (trig_cmd && trig_source != 2'h1 |=>
		!trig_fire) else $error("trigger not ignored");
	sre_back_a: assert property (mask_wr |=>
		sre_readback == $past(sre_wdata, 2)) else $error("mask readback");
	questionable_summary_sum_a: assert property (questionable_summary [*2] |=>
		summary_status_byte[3]) else $error("questionable bit");
	recall_ld_a: assert property (recall_cmd |=>
		cfg_load == ($past(slot) <= 4'h9)) else $error("recall load");
endmodule : srq_status_sva
bind srq_status srq_status_sva chk (.*);
`default_nettype wire

// File: sim/srq_host.sv
`timescale 1ns/10ps
`default_nettype none
module srq_host (
	input wire logic clock,
	input wire logic service_request,
	output var int srq_seen
);
	// Polls the request line each cycle, as a serial poll would
	initial srq_seen = 0;
	always @(posedge clock) if (service_request) srq_seen <= srq_seen + 1;
endmodule : srq_host
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clock, resetn, ese_write, sre_write, esr_read, clear_status;
	logic opc_done, query_error, exec_error, command_error, error_push;
	logic error_pop, local_key, remote_mode, questionable_summary;
	logic msg_available, save_cmd, recall_cmd, trig_cmd, trig_fire;
	logic syntax_scpi_cmd, syntax_native_cmd, service_request, cfg_load;
	logic syntax_native;
	logic [1:0] trig_source;
	logic [3:0] slot, error_count;
	logic [7:0] ese_wdata, sre_wdata, summary_status_byte;
	logic [7:0] standard_event_flags, ese_readback, sre_readback;
	logic [31:0] cfg_in, cfg_out;
	int bad_count = 0, checks = 0, srq_seen;
	srq_status DUT (.*);
	srq_host host (.clock(clock), .service_request(service_request),
		.srq_seen(srq_seen));
	initial begin
		clock = 0;
		forever #10 clock = ~clock;
	end
	task tick(input int n);
		repeat (n) @(negedge clock);
	endtask : tick
	task chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask : chk
	task close_out;
		$display("bad_count=%0d checks=%0d", bad_count, checks);
		if (bad_count == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : close_out
	task t_event;
		{ese_wdata, sre_wdata} = 16'h2020;
		{ese_write, sre_write, command_error} = 3'h7;
		tick(1);
		{ese_write, sre_write, command_error} = 3'h0;
		tick(3);
		chk(standard_event_flags === 8'ha0, "flags");
		chk(ese_readback === 8'h20 && sre_readback === 8'h20, "masks");
		chk(summary_status_byte === 8'h60, "summary");
		chk(srq_seen > 0, "host request");
		clear_status = 1;
		tick(1);
		clear_status = 0;
		tick(2);
		chk(standard_event_flags === 8'h00, "clear");
	endtask : t_event
	task t_bits;
		{opc_done, query_error, exec_error} = 3'h7;
		tick(1);
		{opc_done, query_error, exec_error, esr_read} = 4'h1;
		tick(1);
		esr_read = 0;
		chk(standard_event_flags === 8'h15, "events");
		tick(2);
		chk(standard_event_flags === 8'h00, "query clears");
		{local_key, remote_mode, error_push} = 3'h7;
		{questionable_summary, msg_available} = 2'h3;
		tick(1);
		{local_key, error_push} = 2'h0;
		tick(2);
		chk(summary_status_byte === 8'h1d, "sources");
		chk(error_count === 4'h1, "error count");
		{sre_write, sre_wdata} = 9'h104;
		tick(1);
		{sre_write, error_pop} = 2'h1;
		tick(1);
		error_pop = 0;
		chk(service_request === 1'b1, "request");
		tick(2);
		chk(summary_status_byte === 8'h19, "queue empty");
		chk(error_count === 4'h0, "count empty");
	endtask : t_bits
	task t_store;
		{save_cmd, slot, cfg_in} = {1'b1, 4'h9, 32'h1234abcd};
		tick(1);
		{slot, cfg_in} = {4'h0, 32'h00005a5a};
		tick(1);
		for (int i = 0; i < 3; i++) begin
			{save_cmd, recall_cmd} = 2'h1;
			slot = (i == 0) ? 4'h9 : (i == 1) ? 4'h0 : 4'ha;
			tick(1);
			recall_cmd = 0;
			if (i < 2) chk(cfg_load === 1'b1 && cfg_out ===
				((i == 0) ? 32'h1234abcd : 32'h00005a5a), "recall");
			else chk(cfg_load === 1'b0, "bad slot");
		end
	endtask : t_store
	task t_trig;
		for (int i = 0; i < 3; i++) begin
			{trig_cmd, trig_source} = {1'b1, 2'(i)};
			tick(1);
			chk(trig_fire === (i == 1), "trigger");
		end
		{trig_cmd, syntax_native_cmd} = 2'h1;
		tick(1);
		{syntax_native_cmd, syntax_scpi_cmd} = 2'h0;
		tick(2);
		chk(syntax_native === 1'b1, "native");
		syntax_scpi_cmd = 1;
		tick(1);
		syntax_scpi_cmd = 0;
		tick(2);
		chk(syntax_native === 1'b0, "scpi");
	endtask : t_trig
	initial begin
		{ese_write, sre_write, esr_read, clear_status, opc_done, query_error,
			exec_error, command_error, error_push, error_pop, local_key,
			remote_mode, questionable_summary, msg_available, save_cmd,
			recall_cmd, trig_cmd, syntax_scpi_cmd, syntax_native_cmd,
			trig_source, slot, ese_wdata, sre_wdata, cfg_in} = '0;
		resetn = 0;
		tick(2);
		resetn = 1;
		tick(2);
		chk(standard_event_flags === 8'h80, "power on");
		t_event;
		t_bits;
		t_store;
		t_trig;
		close_out;
	end
	// Whole run is under 100 cycles; generous margin
	initial begin
		#20000;
		bad_count++;
		close_out;
	end
endmodule : tb
`default_nettype wire
